// [logic/csw_pkg.sv]
// Constants and types for the clocked serial interface
package csw_pkg;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [29:0] IDX_MODE = 30'h0000ff82;
  localparam logic [29:0] IDX_PRESC = 30'h0000ff83;
  localparam logic [29:0] IDX_SHIFT = 30'h0000ff84;
  localparam logic [29:0] IDX_LATCH = 30'h0000ff85;
  localparam logic [29:0] IDX_STATUS = 30'h0000ff86;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ==========================================================
  // Reset values, masks and the latch control read value
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PRESC_RESET = 8'h04;
  localparam logic [7:0] MODE_WR_MASK = 8'hcf;
  localparam logic [7:0] LATCH_READ = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int unsigned TXE_BIT = 7;
  localparam int unsigned RXE_BIT = 6;
  localparam int unsigned MODE_HI_BIT = 3;
  localparam int unsigned MODE_LO_BIT = 2;
  localparam int unsigned CLK_HI_BIT = 1;
  localparam int unsigned CLK_LO_BIT = 0;
  localparam int unsigned LATCH_SET_BIT = 1;
  localparam int unsigned LATCH_CLR_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;

  // ==========================================================
  // Clock sources and counts
  typedef enum logic [1:0] {
    CSW_CLK_EXT,
    CSW_CLK_TIMER,
    CSW_CLK_PRESC,
    CSW_CLK_OSC16
  } csw_clk_e;
  localparam int unsigned OSC_DIV = 16;
  localparam logic [7:0] OSC_HALF_LAST = 8'(OSC_DIV / 2 - 1);
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic {
    CSW_IDLE,
    CSW_RUN
  } csw_state_e;

endpackage

// [logic/csw_serial_io.sv]
// Clocked serial interface, 3-wire and 2-wire modes, with APB registers

module csw_serial_io (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic timer_tick_in,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_b_out,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_b_out,
  input wire logic serial_in_pin_in,
  output logic transfer_done_irq_out
);

  // ==========================================================
  // State
  typedef struct packed {
    csw_pkg::csw_state_e st;
    logic [7:0] mode_r;
    logic [7:0] presc_r;
    logic [7:0] shift_r;
    logic latch_r;
    logic [3:0] cnt_r;
    logic sck_r;
    logic [7:0] div_r;
    logic abort_r;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic di_s1;
    logic di_s2;
    logic sd_s1;
    logic sd_s2;
    logic [31:0] prdata_r;
    logic irq_r;
    logic done_r;
  } csw_state_s;

  csw_state_s q;
  csw_state_s n;

  logic tx_en;
  logic rx_en;
  logic any_en;
  logic two_wire;
  logic lsb_first;
  logic ext_clk;
  logic master;
  logic tick;
  logic fall_ev;
  logic rise_ev;
  logic setup;
  logic acc;
  logic hit;
  logic wr_mode;
  logic wr_shift;
  logic rd_shift;
  logic rd_status;
  logic start;
  logic [29:0] idx;
  logic [7:0] rd_byte;
  logic rx_bit;

  // ==========================================================
  // Decode
  assign tx_en = q.mode_r[csw_pkg::TXE_BIT];
  assign rx_en = q.mode_r[csw_pkg::RXE_BIT];
  assign any_en = tx_en | rx_en;
  assign two_wire = q.mode_r[csw_pkg::MODE_HI_BIT];
  assign lsb_first = q.mode_r[csw_pkg::MODE_LO_BIT] & ~two_wire;
  assign ext_clk = csw_pkg::csw_clk_e'(q.mode_r[csw_pkg::CLK_HI_BIT:csw_pkg::CLK_LO_BIT])
                   == csw_pkg::CSW_CLK_EXT;
  assign master = ~ext_clk;
  assign rx_bit = two_wire ? q.sd_s2 : q.di_s2;
  assign idx = paddr_in[31:2];
  assign setup = psel_in & ~penable_in;
  assign acc = psel_in & penable_in;
  assign hit = (paddr_in[1:0] == csw_pkg::WORD_ALIGN) &&
               (idx == csw_pkg::IDX_MODE || idx == csw_pkg::IDX_PRESC ||
                idx == csw_pkg::IDX_SHIFT || idx == csw_pkg::IDX_LATCH ||
                idx == csw_pkg::IDX_STATUS);
  assign wr_mode = acc & pwrite_in & hit & (idx == csw_pkg::IDX_MODE);
  assign wr_shift = acc & pwrite_in & hit & (idx == csw_pkg::IDX_SHIFT);
  assign rd_shift = acc & ~pwrite_in & hit & (idx == csw_pkg::IDX_SHIFT);
  assign rd_status = acc & ~pwrite_in & hit & (idx == csw_pkg::IDX_STATUS);

  // Start: transmit write, receive read, or receive enable rising
  assign start = (wr_shift & tx_en) | (rd_shift & rx_en) |
                 (wr_mode & pwdata_in[csw_pkg::RXE_BIT] & ~rx_en);

  // ==========================================================
  // Serial clock selector
  always_comb begin
    unique case (csw_pkg::csw_clk_e'(q.mode_r[csw_pkg::CLK_HI_BIT:csw_pkg::CLK_LO_BIT]))
      csw_pkg::CSW_CLK_EXT: tick = 1'b0;
      csw_pkg::CSW_CLK_TIMER: tick = timer_tick_in;
      csw_pkg::CSW_CLK_PRESC: tick = q.div_r == q.presc_r;
      csw_pkg::CSW_CLK_OSC16: tick = q.div_r == csw_pkg::OSC_HALF_LAST;
    endcase
  end

  // Edges only count while a transfer runs
  assign fall_ev = (q.st == csw_pkg::CSW_RUN) &&
                   (ext_clk ? (q.ck_s3 & ~q.ck_s2) : (tick & q.sck_r));
  assign rise_ev = (q.st == csw_pkg::CSW_RUN) &&
                   (ext_clk ? (~q.ck_s3 & q.ck_s2) : (tick & ~q.sck_r));

  always_comb begin
    unique case (idx)
      csw_pkg::IDX_MODE: rd_byte = q.mode_r;
      csw_pkg::IDX_PRESC: rd_byte = q.presc_r;
      csw_pkg::IDX_SHIFT: rd_byte = q.shift_r;
      csw_pkg::IDX_STATUS: rd_byte = {6'h00, q.done_r, q.st == csw_pkg::CSW_RUN};
      default: rd_byte = csw_pkg::LATCH_READ;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    n.irq_r = 1'b0;
    n.ck_s1 = serial_clock_pin_in;
    n.ck_s2 = q.ck_s1;
    n.ck_s3 = q.ck_s2;
    n.di_s1 = serial_in_pin_in;
    n.di_s2 = q.di_s1;
    n.sd_s1 = serial_out_pin_in;
    n.sd_s2 = q.sd_s1;
    if (setup) begin
      n.prdata_r = hit ? {24'h000000, rd_byte} : 32'h00000000;
    end
    if (rd_status) begin
      n.done_r = 1'b0;
    end
    if (acc && pwrite_in && hit) begin
      unique case (idx)
        csw_pkg::IDX_MODE: n.mode_r = pwdata_in[7:0] & csw_pkg::MODE_WR_MASK;
        csw_pkg::IDX_PRESC: n.presc_r = pwdata_in[7:0];
        csw_pkg::IDX_SHIFT: n.shift_r = pwdata_in[7:0];
        csw_pkg::IDX_LATCH: begin
          if (pwdata_in[csw_pkg::LATCH_SET_BIT]) begin
            n.latch_r = 1'b1;
          end else if (pwdata_in[csw_pkg::LATCH_CLR_BIT]) begin
            n.latch_r = 1'b0;
          end
        end
        default: n.done_r = n.done_r;
      endcase
    end
    n.div_r = (q.st == csw_pkg::CSW_RUN && !tick) ? q.div_r + 8'h01 : 8'h00;
    unique case (q.st)
      csw_pkg::CSW_IDLE: begin
        n.sck_r = 1'b1;
        n.cnt_r = 4'h0;
        n.abort_r = 1'b0;
        if (start) begin
          n.st = csw_pkg::CSW_RUN;
        end
      end
      csw_pkg::CSW_RUN: begin
        if (!any_en) begin
          if (ext_clk || q.sck_r) begin
            n.st = csw_pkg::CSW_IDLE;
            n.sck_r = 1'b1;
          end else begin
            n.abort_r = 1'b1;
          end
        end
        if (fall_ev && any_en && !q.abort_r) begin
          n.sck_r = 1'b0;
          n.latch_r = lsb_first ? q.shift_r[0] : q.shift_r[7];
        end
        if (rise_ev) begin
          n.sck_r = 1'b1;
          n.shift_r = lsb_first ? {rx_bit, q.shift_r[7:1]} : {q.shift_r[6:0], rx_bit};
          n.cnt_r = q.cnt_r + 4'h1;
          if (q.abort_r || !any_en) begin
            n.st = csw_pkg::CSW_IDLE;
          end else if (q.cnt_r == csw_pkg::LAST_BIT) begin
            n.st = csw_pkg::CSW_IDLE;
            n.irq_r = 1'b1;
            n.done_r = 1'b1;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q.st <= csw_pkg::CSW_IDLE;
      q.mode_r <= csw_pkg::MODE_RESET;
      q.presc_r <= csw_pkg::PRESC_RESET;
      q.shift_r <= csw_pkg::SHIFT_RESET;
      q.latch_r <= 1'b0;
      q.cnt_r <= 4'h0;
      q.sck_r <= 1'b1;
      q.div_r <= 8'h00;
      q.abort_r <= 1'b0;
      q.ck_s1 <= 1'b1;
      q.ck_s2 <= 1'b1;
      q.ck_s3 <= 1'b1;
      q.di_s1 <= 1'b0;
      q.di_s2 <= 1'b0;
      q.sd_s1 <= 1'b1;
      q.sd_s2 <= 1'b1;
      q.prdata_r <= 32'h00000000;
      q.irq_r <= 1'b0;
      q.done_r <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_out = q.prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = acc & ~hit;
  assign transfer_done_irq_out = q.irq_r;
  assign serial_clock_pin_out = two_wire ? 1'b0 : q.sck_r;
  assign serial_clock_pin_oe_b_out = two_wire ? ~(master & ~q.sck_r) : ext_clk;
  assign serial_out_pin_out = two_wire ? 1'b0 : q.latch_r;
  assign serial_out_pin_oe_b_out = two_wire ? ~(tx_en & ~q.latch_r) : ~tx_en;

  // ==========================================================
  // Assertions
  a_done_after_eight: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    q.irq_r |-> ($past(q.cnt_r) == csw_pkg::LAST_BIT && q.st == csw_pkg::CSW_IDLE))
    else $error("done pulse without eight clocks");

  a_sck_idle_high: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    q.st == csw_pkg::CSW_IDLE |-> q.sck_r)
    else $error("serial clock not high while idle");

  a_tx_off_float: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !tx_en |-> serial_out_pin_oe_b_out)
    else $error("data pin driven with transmit off");

  a_mode_write_stored: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_mode |=> q.mode_r == ($past(pwdata_in[7:0]) & csw_pkg::MODE_WR_MASK))
    else $error("mode write not stored");

  a_latch_reads_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (setup && idx == csw_pkg::IDX_LATCH && paddr_in[1:0] == csw_pkg::WORD_ALIGN)
    |=> prdata_out == 32'h00000000)
    else $error("latch control read not zero");

  a_ext_no_drive: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (ext_clk && !two_wire) |-> serial_clock_pin_oe_b_out)
    else $error("clock driven in slave mode");

  a_ext_abort_now: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (ext_clk && q.st == csw_pkg::CSW_RUN && !any_en)
    |=> (q.st == csw_pkg::CSW_IDLE && !q.irq_r))
    else $error("external abort not immediate");

  a_tx_start: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (wr_shift && tx_en && q.st == csw_pkg::CSW_IDLE) |=> q.st == csw_pkg::CSW_RUN)
    else $error("shift write did not start transfer");

  a_idle_count_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (q.st == csw_pkg::CSW_IDLE && $past(q.st) == csw_pkg::CSW_IDLE) |-> q.cnt_r == 4'h0)
    else $error("counter not cleared while idle");

  a_int_abort_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (q.abort_r && rise_ev) |=> (q.st == csw_pkg::CSW_IDLE && !q.irq_r))
    else $error("internal abort raised done");

  a_irq_one_cycle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    q.irq_r |=> !q.irq_r)
    else $error("done pulse longer than one cycle");

  a_count_in_range: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    q.st == csw_pkg::CSW_RUN |-> q.cnt_r <= csw_pkg::LAST_BIT)
    else $error("bit counter past eight while running");

  a_latch_set_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (acc && pwrite_in && hit && idx == csw_pkg::IDX_LATCH && q.st == csw_pkg::CSW_IDLE &&
     pwdata_in[csw_pkg::LATCH_SET_BIT]) |=> q.latch_r)
    else $error("latch set write not applied");

  a_sck_on_tick: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (master && q.st == csw_pkg::CSW_RUN && !tick) |=> $stable(q.sck_r))
    else $error("serial clock moved without a tick");

  a_ext_idle_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (ext_clk && q.st == csw_pkg::CSW_IDLE && !(acc && pwrite_in))
    |=> ($stable(q.shift_r) && $stable(q.latch_r)))
    else $error("idle external clock changed data");

  a_two_wire_low: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    two_wire |-> (!serial_out_pin_out && !serial_clock_pin_out))
    else $error("open-drain pin driven high");

  a_push_pull_out: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (!two_wire && tx_en) |-> (!serial_out_pin_oe_b_out && serial_out_pin_out == q.latch_r))
    else $error("3-wire data pin not driven from latch");

  a_master_drives: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (master && !two_wire) |-> (!serial_clock_pin_oe_b_out && serial_clock_pin_out == q.sck_r))
    else $error("master clock not driven");

  a_lsb_bit_out: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (fall_ev && any_en && !q.abort_r && lsb_first) |=> q.latch_r == $past(q.shift_r[0]))
    else $error("first bit not taken from the low end");

  a_rx_start: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (wr_mode && pwdata_in[csw_pkg::RXE_BIT] && !rx_en && q.st == csw_pkg::CSW_IDLE)
    |=> q.st == csw_pkg::CSW_RUN)
    else $error("receive enable did not start a transfer");

endmodule

// [sim/csw_peer.sv]
// Far-side serial peer that swaps one byte with the block
module csw_peer (
  input wire logic sck_in,
  input wire logic sdo_in,
  input wire logic [7:0] tx_in,
  input wire logic load_in,
  output logic sdi_out,
  output logic [7:0] rx_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_r;
  // Sample on the rising clock edge, first bit lands at the top
  always @(posedge sck_in) rx_out = {rx_out[6:0], sdo_in};
  // Load a byte, or next bit on the falling edge, stale data inverted afterwards
  always @(posedge load_in or negedge sck_in) begin
    if (load_in) begin
      tx_r = tx_in;
      sdi_out = ~tx_in[7];
    end else begin
      sdi_out = tx_r[7];
      tx_r = {tx_r[6:0], ~tx_r[7]};
    end
  end
endmodule

// [sim/clocked_serial_3wire_2wire_tb.sv]
// Self-checking bench for the clocked serial block
module clocked_serial_3wire_2wire_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_MODE = {csw_pkg::IDX_MODE, csw_pkg::WORD_ALIGN};
  localparam logic [31:0] A_PRE = {csw_pkg::IDX_PRESC, csw_pkg::WORD_ALIGN};
  localparam logic [31:0] A_SH = {csw_pkg::IDX_SHIFT, csw_pkg::WORD_ALIGN};
  localparam logic [31:0] A_LAT = {csw_pkg::IDX_LATCH, csw_pkg::WORD_ALIGN};
  localparam logic [31:0] A_ST = {csw_pkg::IDX_STATUS, csw_pkg::WORD_ALIGN};
  logic clk, rst_b, psel, pen, pwr, pready, perr, tick, sck, sck_oe_b, so, so_oe_b, irq;
  logic ext_en, ext_sck, pld, sdi;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] ptx, prx;
  logic [1:0] tcnt;
  int errors, cmp_count, rises, irqs;
  wire sck_w = !sck_oe_b ? sck : (ext_en ? ext_sck : 1'b1);
  wire so_w = !so_oe_b ? so : 1'b1;
  csw_serial_io u_dut (.mclk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .timer_tick_in(tick),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck),
    .serial_clock_pin_oe_b_out(sck_oe_b), .serial_out_pin_in(so_w),
    .serial_out_pin_out(so), .serial_out_pin_oe_b_out(so_oe_b),
    .serial_in_pin_in(sdi), .transfer_done_irq_out(irq));
  csw_peer u_peer (.sck_in(sck_w), .sdo_in(so_w), .tx_in(ptx), .load_in(pld),
    .sdi_out(sdi), .rx_out(prx));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge sck_w) rises++;
  always @(posedge clk) begin
    if (irq === 1'b1) irqs++;
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h0);
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      end_sim();
    end
    r = prdata;
    e = perr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic need_done;
    int n0, n;
    n0 = irqs;
    for (n = 0; n < 3000 && irqs == n0; n++) @(posedge clk);
    if (irqs == n0) begin
      errors++;
      end_sim();
    end
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      ext_sck <= 1'b0;
      repeat (6) @(posedge clk);
      ext_sck <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    apb(1'b0, A_MODE, 0, r, e); chk(r, 32'h00);
    apb(1'b0, A_PRE, 0, r, e); chk(r, 32'h04);
    apb(1'b0, A_LAT, 0, r, e); chk(r, 32'h00);
    apb(1'b0, 32'h0000_0100, 0, r, e); chk(r, 32'h00);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_xfer(input logic [7:0] mode, input logic [7:0] d, input logic lsb);
    logic [31:0] r;
    logic e;
    wr(A_MODE, mode);
    ptx <= 8'h3c; pld <= 1'b1;
    @(posedge clk);
    pld <= 1'b0; rises = 0;
    wr(A_SH, d);
    need_done();
    chk(rises, 8);
    chk(prx, lsb ? rev(d) : d);
    @(posedge clk); chk(sck_w, 1);
    apb(1'b0, A_SH, 0, r, e); chk(r, lsb ? rev(8'h3c) : 8'h3c);
    wr(A_MODE, 8'h00);
  endtask
  task automatic t_rx;
    logic [31:0] r;
    logic e;
    ptx <= 8'hc3; pld <= 1'b1;
    @(posedge clk);
    pld <= 1'b0;
    wr(A_MODE, 8'h43);
    need_done();
    apb(1'b0, A_ST, 0, r, e); chk(r, 32'h02);
    apb(1'b0, A_SH, 0, r, e); chk(r, 32'hc3);
    need_done();
    wr(A_MODE, 8'h00);
  endtask
  task automatic t_modes;
    logic [31:0] r;
    logic e;
    wr(A_PRE, 8'h03);
    apb(1'b0, A_PRE, 0, r, e); chk(r, 32'h03);
    t_xfer(8'h81, 8'ha5, 1'b0);
    t_xfer(8'h82, 8'h81, 1'b0);
    t_xfer(8'h83, 8'h4e, 1'b0);
    t_xfer(8'h87, 8'h4e, 1'b1);
  endtask
  task automatic t_abort;
    int n0;
    wr(A_MODE, 8'h83);
    wr(A_SH, 8'hff);
    repeat (40) @(posedge clk);
    n0 = irqs;
    wr(A_MODE, 8'h03);
    repeat (300) @(posedge clk);
    chk(irqs, n0);
    chk({sck_w, so_oe_b}, 2'b11);
    t_xfer(8'h83, 8'h5a, 1'b0);
  endtask
  task automatic t_ext;
    int n0;
    logic s;
    wr(A_MODE, 8'h80);
    ext_en <= 1'b1;
    @(posedge clk);
    s = so;
    pulses(2);
    chk(so, s);
    n0 = irqs;
    wr(A_SH, 8'h96);
    pulses(8);
    repeat (10) @(posedge clk);
    chk(irqs, n0 + 1);
    chk(prx, 8'h96);
    wr(A_SH, 8'h33);
    pulses(3);
    wr(A_MODE, 8'h00);
    pulses(8);
    chk(irqs, n0 + 1);
    chk(so_oe_b, 1'b1);
    ext_en <= 1'b0;
  endtask
  task automatic t_latch;
    logic [31:0] r;
    logic e;
    wr(A_MODE, 8'h80);
    wr(A_LAT, 8'h02);
    @(posedge clk); chk({so, so_oe_b}, 2'b10);
    apb(1'b0, A_LAT, 0, r, e); chk(r, 32'h00);
    wr(A_LAT, 8'h01);
    @(posedge clk); chk({so, so_oe_b}, 2'b00);
    wr(A_MODE, 8'h88);
    @(posedge clk); chk(so_oe_b, 0);
    wr(A_LAT, 8'h02);
    @(posedge clk); chk(so_oe_b, 1);
    wr(A_MODE, 8'h00);
    @(posedge clk); chk(so_oe_b, 1);
  endtask
  initial begin
    rst_b = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; tick = 0; tcnt = 0;
    ext_en = 0; ext_sck = 1; pld = 0; ptx = 8'h00; errors = 0; cmp_count = 0;
    rises = 0; irqs = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_abort();
    t_rx();
    t_ext();
    t_latch();
    end_sim();
  end
endmodule
